// file: design/lcd_cmd_regs.vh
// Summary of operation
// - frame opens with three-bit identifier
// - write: seven address bits, nibble lowest first
// - read drives nibble out on strobe falls
// - write id also does read-modify-write
// - seven-bit word address, four-bit words
// - 0000-0000 stops oscillator
// - 0000-0001 starts oscillator
// - 0000-0010 bias generator off
// - 0000-0011 bias generator on
// - 0000-0100 time base output off
// - 0000-0101 watchdog flag output off
// - 0000-0110 time base drives flag
// - 0000-0111 watchdog drives flag
// - tone off, 4 kHz, 2 kHz codes
// - 0000-11xx clears time base counter
// - 0000-111x also clears watchdog stage
// - rate 2^n Hz, watchdog after four
// - reset defaults: off, off, rc, 128 Hz
// - sample on write rise, drive on read fall
// - select high ends frame, resets decoder
// - time base enable reroutes flag source
// - flag pin gated by enable/disable
`ifndef LCD_CMD_REGS_VH
`define LCD_CMD_REGS_VH
// ************************************************************
// identifiers and timing
// ************************************************************
`define ID_READ        3'h6
`define ID_WRITE       3'h5
`define ID_CMD         3'h4
`define ADDR_BITS      7
`define NIBBLE_BITS    4
`define CMD_BITS       9
`define RATE_RESET     3'h7
`define SYS_HZ         32768
`define CLK_HZ         40000000
`define TONE4_HZ       4096
`define TONE2_HZ       2048
`define WDT_PERIODS    4
`endif

// file: design/lcd_serial_command_decoder.v
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "lcd_cmd_regs.vh"
module lcd_serial_command_decoder #(
  parameter SYS_DIV = `CLK_HZ / `SYS_HZ    // 40 MHz cycles per 32 kHz tick
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // serial pins from the host
  input  wire       cs_n,
  input  wire       wr_n,
  input  wire       rd_n,
  input  wire       data_in,
  output reg        data_out,
  output reg        data_oe,
  // flag pin, open drain: enable high pulls low
  output reg        flag_oe,
  // tone outputs
  output reg        tone_out_p,
  output reg        tone_out_n,
  // status levels
  output reg        osc_on,
  output reg        bias_on,
  output reg        ext_clk_sel,
  output reg        test_mode
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  reg [2:0] sync_a;                 // first stage, read only by sync_b
  reg [2:0] sync_b;                 // second stage
  reg [2:0] sync_c;                 // delayed copy for edge detection
  reg       din_a;                  // data first stage
  reg       din_b;                  // data second stage

  // two flops on every pin before logic looks at it
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      sync_c <= 3'h7;
      din_a  <= 1'b1;
      din_b  <= 1'b1;
    end else begin
      sync_a <= {cs_n, wr_n, rd_n};
      sync_b <= sync_a;
      sync_c <= sync_b;
      din_a  <= data_in;
      din_b  <= din_a;
    end
  end

  wire cs_act  = ~sync_b[2];                      // select low
  wire wr_rise = sync_b[1] & ~sync_c[1] & cs_act; // latch point
  wire rd_fall = ~sync_b[0] & sync_c[0] & cs_act; // drive point

  // ************************************************************
  // serial decoder
  // ************************************************************
  localparam ST_ID   = 3'h0;        // collecting identifier
  localparam ST_ADDR = 3'h1;        // collecting address
  localparam ST_DATA = 3'h2;        // data nibbles
  localparam ST_CMD  = 3'h3;        // command words
  localparam ST_IDLE = 3'h4;        // unknown id, wait for select high

  reg [2:0]  state;                 // decoder state
  reg [3:0]  bit_cnt;               // bits taken in current field
  reg [8:0]  shreg;                 // shift register
  reg [6:0]  addr;                  // current word address
  reg        is_read;               // read frame
  reg        rd_seen;               // read strobe seen in this nibble
  reg [3:0]  rd_nib;                // nibble being shifted out
  reg [3:0]  ram [0:127];           // display memory, 128 x 4
  reg        we;                    // write pulse to memory
  reg [3:0]  wdata;                 // nibble to write
  reg        cmd_stb;               // one-cycle command pulse
  reg [8:0]  cmd_word;              // captured command

  // memory written from the decoder pulse
  always @(posedge clk_sys) begin
    if (we) begin
      ram[addr] <= wdata;
    end
  end

  // frame sequencing on synchronised strobes
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state    <= ST_ID;
      bit_cnt  <= 4'h0;
      shreg    <= 9'h000;
      addr     <= 7'h00;
      is_read  <= 1'b0;
      rd_seen  <= 1'b0;
      rd_nib   <= 4'h0;
      we       <= 1'b0;
      wdata    <= 4'h0;
      cmd_stb  <= 1'b0;
      cmd_word <= 9'h000;
      data_out <= 1'b0;
      data_oe  <= 1'b0;
    end else begin
      we      <= 1'b0;
      cmd_stb <= 1'b0;
      if (we) begin
        addr <= addr + 7'h01;       // next group, next word
      end
      if (!cs_act) begin            // select high ends frame
        state   <= ST_ID;
        bit_cnt <= 4'h0;
        data_oe <= 1'b0;
        rd_seen <= 1'b0;
      end else begin
        case (state)
          ST_ID: begin
            if (wr_rise) begin
              shreg   <= {shreg[7:0], din_b};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h2) begin
                bit_cnt <= 4'h0;
                is_read <= ({shreg[1:0], din_b} == `ID_READ);
                if ({shreg[1:0], din_b} == `ID_READ ||
                    {shreg[1:0], din_b} == `ID_WRITE) begin
                  state <= ST_ADDR;
                end else if ({shreg[1:0], din_b} == `ID_CMD) begin
                  state <= ST_CMD;
                end else begin
                  state <= ST_IDLE;
                end
              end
            end
          end
          ST_ADDR: begin
            if (wr_rise) begin
              shreg   <= {shreg[7:0], din_b};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h6) begin
                addr    <= {shreg[5:0], din_b};  // msb first
                bit_cnt <= 4'h0;
                rd_nib  <= ram[{shreg[5:0], din_b}];
                state   <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            // read path: one bit per read fall, lowest first
            if (rd_fall) begin
              data_oe <= 1'b1;
              rd_seen <= 1'b1;
              data_out <= rd_nib[0];
              rd_nib  <= {1'b0, rd_nib[3:1]};
              bit_cnt <= bit_cnt + 4'h1;
              if (is_read && bit_cnt == 4'h3) begin
                bit_cnt <= 4'h0;
                addr    <= addr + 7'h01;
                rd_nib  <= ram[addr + 7'h01];
              end
            end
            // write path: write strobe after read turns line around
            if (wr_rise && !is_read) begin
              data_oe <= 1'b0;
              if (rd_seen) begin
                bit_cnt <= 4'h0;
                rd_seen <= 1'b0;
              end
              wdata   <= {din_b, wdata[3:1]};    // lowest first
              bit_cnt <= rd_seen ? 4'h1 : bit_cnt + 4'h1;
              if (!rd_seen && bit_cnt == 4'h3) begin
                bit_cnt <= 4'h0;
                we      <= 1'b1;                 // store nibble
                rd_nib  <= ram[addr + 7'h01];
              end
            end
          end
          ST_CMD: begin
            if (wr_rise) begin
              shreg   <= {shreg[7:0], din_b};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h8) begin
                bit_cnt  <= 4'h0;                // next command follows
                cmd_word <= {shreg[7:0], din_b};
                cmd_stb  <= 1'b1;
              end
            end
          end
          default: begin
            bit_cnt <= 4'h0;        // ignore until select rises
          end
        endcase
      end
    end
  end

  // ************************************************************
  // configuration
  // ************************************************************
  reg       tb_en;                  // time base generator running
  reg       watchdog_flag_on_cmd;                 // watchdog flag enabled
  reg       src_tb;                 // flag source: 1 time base, 0 watchdog
  reg       flag_en;                // global flag gate
  reg       tone_en;                // tone running
  reg       tone_hi;                // 1: 4 kHz, 0: 2 kHz
  reg [2:0] rate;                   // time base rate exponent
  reg       clr_tb;                 // clear time base pulse
  reg       watchdog_clear_cmd;                // clear watchdog pulse
  wire [7:0] op = cmd_word[8:1];    // trailing bit dropped

  // command decode, don't-care bits masked
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_on      <= 1'b0;
      bias_on     <= 1'b0;
      tone_en     <= 1'b0;
      tone_hi     <= 1'b0;
      ext_clk_sel <= 1'b0;
      flag_en     <= 1'b0;
      rate        <= `RATE_RESET;
      test_mode   <= 1'b0;
      tb_en       <= 1'b0;
      watchdog_flag_on_cmd      <= 1'b0;
      src_tb      <= 1'b0;
      clr_tb      <= 1'b0;
      watchdog_clear_cmd     <= 1'b0;
    end else begin
      clr_tb  <= 1'b0;
      watchdog_clear_cmd <= 1'b0;
      if (cmd_stb) begin
        if (op == 8'h00) begin
          osc_on <= 1'b0;
        end else if (op == 8'h01) begin
          osc_on <= 1'b1;
        end else if (op == 8'h02) begin
          bias_on <= 1'b0;
        end else if (op == 8'h03) begin
          bias_on <= 1'b1;
        end else if (op == 8'h04) begin
          tb_en <= 1'b0;
        end else if (op == 8'h05) begin
          watchdog_flag_on_cmd <= 1'b0;
        end else if (op == 8'h06) begin
          tb_en  <= 1'b1;
          src_tb <= 1'b1;
        end else if (op == 8'h07) begin
          watchdog_flag_on_cmd <= 1'b1;
          tb_en  <= 1'b1;
          src_tb <= 1'b0;
        end else if (op == 8'h08) begin
          tone_en <= 1'b0;
        end else if (op[7:2] == 6'h03) begin
          clr_tb  <= 1'b1;
          watchdog_clear_cmd <= op[1];
        end else if (op[7:2] == 6'h06) begin
          ext_clk_sel <= 1'b0;
        end else if (op[7:2] == 6'h07) begin
          ext_clk_sel <= 1'b1;
        end else if (op[7:5] == 3'h2) begin
          tone_en <= 1'b1;
          tone_hi <= 1'b1;
        end else if (op[7:5] == 3'h3) begin
          tone_en <= 1'b1;
          tone_hi <= 1'b0;
        end else if (op[7:5] == 3'h4) begin
          flag_en <= op[3];
        end else if (op[7:5] == 3'h5) begin
          rate <= op[2:0];
        end else if (op == 8'he0) begin
          test_mode <= 1'b1;
        end else if (op == 8'he3) begin
          test_mode <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // 32 kHz tick, time base, watchdog, tone
  // ************************************************************
  reg [11:0] div_cnt;               // divides clk_sys to the 32 kHz tick
  reg        tick;                  // one-cycle 32 kHz enable
  reg [14:0] tb_cnt;                // shared time base counter
  reg [1:0]  wdt_cnt;               // extra watchdog stage
  reg        wdt_flag;              // watchdog time-out flag
  reg        tb_flag;               // time base overflow flag
  reg [3:0]  tone_cnt;              // free 32 kHz count for the tone pair
  wire [14:0] tb_next = tb_cnt + 15'h0001;
  // overflow bit for rate 2^n Hz is bit 14-n of the counter
  wire [3:0]  ov_bit  = 4'he - {1'b0, rate};
  wire        ov      = tb_cnt[ov_bit] & ~tb_next[ov_bit];
  wire        tb_step = tick & tb_en;          // counter advances this cycle
  wire        tb_wrap = tb_step & ov;          // a period of the chosen rate ends

  // divider: stops with the oscillator, saving power when off
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      div_cnt <= 12'h000;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (osc_on) begin
        if (div_cnt == SYS_DIV[11:0] - 12'h001) begin
          div_cnt <= 12'h000;
          tick    <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 12'h001;
        end
      end
    end
  end

  // time base and watchdog; a flag event beats a clear in the same cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tb_cnt   <= 15'h0000;
      wdt_cnt  <= 2'h0;
      wdt_flag <= 1'b0;
      tb_flag  <= 1'b0;
    end else begin
      // counter: clear first, otherwise count on the enabled tick
      if (clr_tb) begin
        tb_cnt  <= 15'h0000;
        tb_flag <= 1'b0;
      end else if (tb_step) begin
        tb_cnt <= tb_next;
      end
      // extra watchdog stage, cleared only by the watchdog clear
      if (clr_tb && watchdog_clear_cmd) begin
        wdt_cnt  <= 2'h0;
        wdt_flag <= 1'b0;
      end else if (tb_wrap) begin
        wdt_cnt <= wdt_cnt + 2'h1;
      end
      // set wins: a period end is never lost to a clear
      if (tb_wrap) begin
        tb_flag <= 1'b1;
        if (wdt_cnt == 2'h3) begin
          wdt_flag <= 1'b1;          // four periods elapsed
        end
      end
    end
  end

  // tone prescaler kept apart from the time base, so a tone needs no
  // time base enable and is not disturbed by a time base clear;
  // costs four flops
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tone_cnt <= 4'h0;
    end else if (tick) begin
      tone_cnt <= tone_cnt + 4'h1;
    end
  end

  // flag pin, tone pair
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_oe    <= 1'b0;
      tone_out_p <= 1'b0;
      tone_out_n <= 1'b0;
    end else begin
      flag_oe <= flag_en &
                 (src_tb ? (tb_en & tb_flag) : (watchdog_flag_on_cmd & wdt_flag));
      if (tone_en && osc_on) begin
        // bits 2 and 3 of the prescaler give 4 and 2 kHz squares
        tone_out_p <= tone_hi ? tone_cnt[2] : tone_cnt[3];
        tone_out_n <= tone_hi ? ~tone_cnt[2] : ~tone_cnt[3];
      end else begin
        tone_out_p <= 1'b0;          // both low when silent
        tone_out_n <= 1'b0;
      end
    end
  end

endmodule // lcd_serial_command_decoder

// file: sim/lcd_host_model.sv
`timescale 1ns/10ps
// host side of the serial link
module lcd_host_model (
  // clock
  input  wire logic clk_sys,
  // device pins
  output logic      cs_n,
  output logic      wr_n,
  output logic      rd_n,
  output logic      data_in,
  input  wire logic data_out,
  input  wire logic data_oe
);
  logic host_en;  // host drives the line
  logic host_bit; // level the host drives
  // host wins the turnaround clock; a released line floats to its pull-up
  assign data_in = host_en ? host_bit : (data_oe ? data_out : 1'b1);
  // all pins idle high
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    host_en = 1'b0;
    host_bit = 1'b0;
  end
  // wait n clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // open or close a frame; closing resets the decoder
  task automatic frame(input logic on);
    tick(2);
    cs_n <= ~on;
    host_en <= 1'b0;
    tick(2);
  endtask
  // one bit, taken on the write strobe rise, 200 ns period
  task automatic put(input logic b);
    wr_n <= 1'b0;
    host_en <= 1'b1;
    host_bit <= b;
    tick(4);
    wr_n <= 1'b1;
    tick(4);
  endtask
  // one nibble, lowest bit first, each after a read strobe fall
  task automatic get(output logic [3:0] v);
    host_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_n <= 1'b0;
      tick(5);
      v[i] = data_in;
      rd_n <= 1'b1;
      tick(3);
    end
  endtask
endmodule // lcd_host_model

// file: sim/lcd_serial_command_decoder_asserts.sv
`timescale 1ns/10ps
// watches the decoder's ports only
module lcd_decoder_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic data_in,
  input wire logic data_out,
  input wire logic data_oe,
  // flag, tone and status
  input wire logic flag_oe,
  input wire logic tone_out_p,
  input wire logic tone_out_n,
  input wire logic osc_on,
  input wire logic bias_on,
  input wire logic ext_clk_sel,
  input wire logic test_mode
);
  logic       wr_q;   // strobe levels one clock back
  logic       rd_q;
  logic [3:0] wr_age; // clocks since write rise, saturating
  logic [3:0] rd_age; // clocks since read fall, saturating
  // saturation keeps an old edge from looking fresh
  always_ff @(posedge clk_sys) begin
    wr_q <= wr_n;
    rd_q <= rd_n;
    if (!rst_n) begin
      wr_age <= 4'hf;
      rd_age <= 4'hf;
    end else begin
      wr_age <= (wr_n && !wr_q) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
      rd_age <= (!rd_n && rd_q) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reset_dflt_a: assert property (
    $rose(rst_n) |-> !osc_on && !bias_on && !ext_clk_sel && !test_mode && !flag_oe)
    else $error("outputs not at reset defaults");
  out_cause_a: assert property (
    $changed(data_out) || $rose(data_oe) |-> rd_age < 4'h6)
    else $error("read data moved without a read strobe fall");
  cfg_cause_a: assert property (
    $changed(osc_on) || $changed(bias_on) || $changed(ext_clk_sel) || $changed(test_mode)
    |-> wr_age < 4'h8) else $error("setting moved without a command bit");
  oe_release_a: assert property (
    $rose(wr_n) && !cs_n |-> ##[1:5] !data_oe) else $error("data kept after write");
  cs_end_a: assert property (
    $rose(cs_n) |-> ##[1:5] !data_oe) else $error("data kept after deselect");
  idle_quiet_a: assert property (
    cs_n [*6] |-> !data_oe) else $error("data driven while deselected");
  tone_pair_a: assert property (
    tone_out_p |-> !tone_out_n) else $error("tone pair not complementary");
  tone_quiet_a: assert property (
    !osc_on && !$past(osc_on) |-> !tone_out_p && !tone_out_n)
    else $error("tone driven with oscillator stopped");
  flag_src_a: assert property (
    $rose(flag_oe) |-> osc_on) else $error("flag without running oscillator");
  cover property ($rose(data_oe));
  cover property ($rose(flag_oe));
  cover property ($rose(tone_out_p));
endmodule // lcd_decoder_checker

// file: sim/test_lcd_serial_command_decoder.sv
`timescale 1ns/10ps
module test_lcd_serial_command_decoder;
  // clock and reset
  logic clk_sys = 1'b0;
  logic rst_n   = 1'b0;
  // pins and levels
  wire  cs_n, wr_n, rd_n, data_in, data_out, data_oe, flag_oe;
  wire  tone_out_p, tone_out_n, osc_on, bias_on, ext_clk_sel, test_mode;
  int   n_mismatch = 0;
  int   n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;
  // short tick divider keeps the watchdog run brief
  lcd_serial_command_decoder #(.SYS_DIV(4)) lcd_serial_command_decoder_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .flag_oe(flag_oe),
    .tone_out_p(tone_out_p), .tone_out_n(tone_out_n), .osc_on(osc_on),
    .bias_on(bias_on), .ext_clk_sel(ext_clk_sel), .test_mode(test_mode));
  lcd_host_model lcd_host_model_inst (.clk_sys(clk_sys), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  // ****************
  // checks and verdict
  // ****************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic in_range(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ****************
  // frame helpers
  // ****************
  task automatic hdr(input logic [9:0] w); // id then address msb first
    lcd_host_model_inst.frame(1'b1);
    for (int i = 9; i >= 0; i--)
      lcd_host_model_inst.put(w[i]);
  endtask
  task automatic nib(input logic [3:0] d); // lowest bit first
    for (int i = 0; i < 4; i++)
      lcd_host_model_inst.put(d[i]);
  endtask
  task automatic chk_nib(input logic [3:0] exp);
    logic [3:0] v;
    lcd_host_model_inst.get(v);
    cmp({4'h0, v}, {4'h0, exp});
  endtask
  task automatic cmd(input logic [8:0] c); // id 100 and nine code bits
    hdr({3'h4, c[8:2]});
    lcd_host_model_inst.put(c[1]);
    lcd_host_model_inst.put(c[0]);
    lcd_host_model_inst.frame(1'b0);
    lcd_host_model_inst.tick(6);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_cmds(); // don't-care bits set high in some codes
    logic [8:0] code [8] = '{9'h003, 9'h007, 9'h03f, 9'h037, 9'h004, 9'h000, 9'h1c1, 9'h1c6};
    logic [3:0] lvl [8] = '{4'h8, 4'hc, 4'he, 4'hc, 4'h8, 4'h0, 4'h1, 4'h0};
    for (int i = 0; i < 8; i++) begin
      cmd(code[i]);
      cmp({4'h0, osc_on, bias_on, ext_clk_sel, test_mode}, {4'h0, lvl[i]});
    end
  endtask
  task automatic t_mem(); // top address wraps to zero
    hdr({3'h5, 7'h7f});
    nib(4'ha);
    nib(4'h5);
    lcd_host_model_inst.frame(1'b0);
    hdr({3'h6, 7'h7f});
    chk_nib(4'ha);
    chk_nib(4'h5);
    lcd_host_model_inst.frame(1'b0);
  endtask
  task automatic t_rmw(); // read then replace, twice in a row
    hdr({3'h5, 7'h7f});
    chk_nib(4'ha);
    nib(4'h3);
    chk_nib(4'h5);
    nib(4'hc);
    lcd_host_model_inst.frame(1'b0);
    hdr({3'h6, 7'h7f});
    chk_nib(4'h3);
    chk_nib(4'hc);
    lcd_host_model_inst.frame(1'b0);
  endtask
  task automatic t_flag(); // 128 Hz rate, watchdog on the flag pin
    int n;
    cmd(9'h002);
    cmd(9'h14e);
    cmd(9'h00e);
    cmd(9'h110);
    cmd(9'h01c);
    n = 0;
    while (flag_oe !== 1'b1 && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
    in_range(n, 3600, 4200);
    if (n == 6000)
      complete_run();
    cmd(9'h01c);
    cmp({7'h0, flag_oe}, 8'h00);
    cmd(9'h100);
    repeat (4300) @(posedge clk_sys);
    cmp({7'h0, flag_oe}, 8'h00);
  endtask
  task automatic t_source(); // flag source routing and its gates
    int n;
    cmd(9'h110);
    cmp({7'h0, flag_oe}, 8'h01);
    cmd(9'h00c);
    cmd(9'h018);
    cmp({7'h0, flag_oe}, 8'h00);
    n = 0;
    while (flag_oe !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    in_range(n, 900, 1100);
    if (n == 2000)
      complete_run();
    cmd(9'h008);
    cmp({7'h0, flag_oe}, 8'h00);
    cmd(9'h00e);
    cmp({7'h0, flag_oe}, 8'h01);
    cmd(9'h00a);
    cmp({7'h0, flag_oe}, 8'h00);
  endtask
  task automatic t_tone(input logic [8:0] c, input int lo, input int hi);
    int  n;
    logic q;
    n = 0;
    cmd(c);
    @(negedge clk_sys);
    q = tone_out_p;
    repeat (1024) begin
      @(negedge clk_sys);
      n += (tone_out_p !== q);
      q = tone_out_p;
    end
    in_range(n, lo, hi);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp({osc_on, bias_on, ext_clk_sel, test_mode, flag_oe, data_oe, tone_out_p,
         tone_out_n}, 8'h00);
    t_cmds();
    t_mem();
    t_rmw();
    t_flag();
    t_source();
    t_tone(9'h0bf, 62, 66);
    t_tone(9'h0c0, 30, 34);
    t_tone(9'h010, 0, 0);
    cmp({6'h0, tone_out_p, tone_out_n}, 8'h00);
    cmd(9'h0bf);
    cmd(9'h000);
    cmp({6'h0, tone_out_p, tone_out_n}, 8'h00);
    complete_run();
  end
endmodule // test_lcd_serial_command_decoder
bind lcd_serial_command_decoder lcd_decoder_checker lcd_decoder_checker_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .flag_oe(flag_oe),
  .tone_out_p(tone_out_p), .tone_out_n(tone_out_n), .osc_on(osc_on),
  .bias_on(bias_on), .ext_clk_sel(ext_clk_sel), .test_mode(test_mode));
